/* File: rtl/ccc_defs.vh */
`ifndef CCC_DEFS_VH
`define CCC_DEFS_VH

// timing
`define CCC_CLK_MHZ        24'h000064
`define CCC_POR_TIME_US    24'h002710
`define CCC_SEL_SETTLE_US  24'h0003E8
`define CCC_NVM_OP_CYCLES  8'h40

// bus addresses, 7-bit form
`define CCC_ADDR_PRI       7'h6A
`define CCC_ADDR_SEC       7'h68

// register numbers on the serial bus
`define CCC_REG_FLAGS      8'h00
`define CCC_REG_PIN        8'h10
`define CCC_REG_XTAL       8'h12
`define CCC_REG_OUT        8'h20
`define CCC_REG_SPREAD     8'h22

// byte slots inside the configuration word
`define CCC_NREG           5
`define CCC_IDX_FLAGS      3'h0
`define CCC_IDX_PIN        3'h1
`define CCC_IDX_XTAL       3'h2
`define CCC_IDX_OUT        3'h3
`define CCC_IDX_SPREAD     3'h4
`define CCC_IDX_NONE       3'h7

// field positions
`define CCC_FLAG_BIT       7
`define CCC_ADDR_BIT       0
`define CCC_POL_BIT        1
`define CCC_FN_BIT         0
`define CCC_SAVE_BIT       3
`define CCC_RESTORE_BIT    0
`define CCC_SS_EN_BIT      7
`define CCC_SS_DOWN_BIT    6

// field values
`define CCC_XTAL_BASE      7'h12
`define CCC_SS_CODE_MIN    4'h1
`define CCC_SS_CODE_MAX    4'hA
`define CCC_SLOT_I2C       3'h4
`define CCC_NSLOT          5
`define CCC_SYNC_RST       6'h30

`endif

/* File: rtl/ccc_nvm_store.v */
module ccc_nvm_store #(
  parameter         W    = 40,
  parameter         N    = 5,
  parameter [W*N-1:0] INIT = {W*N{1'b0}}
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire         ce,
  input  wire         rd_en,
  input  wire         wr_en,
  input  wire [2:0]   slot,
  input  wire [W-1:0] wdata,
  output reg  [W-1:0] rdata_q
);

  reg [W-1:0] mem_q [0:N-1];
  integer     i;

  wire hit = ({29'h0, slot} < N);

  // reset preloads the contents so a bench sees defined banks
  always @(posedge clk_sys) begin
    if (rst) begin
      for (i = 0; i < N; i = i + 1) begin
        mem_q[i] <= INIT[i*W +: W];
      end
      rdata_q <= {W{1'b0}};
    end else if (ce) begin
      if (wr_en && hit) begin
        mem_q[slot] <= wdata;
      end
      if (rd_en) begin
        rdata_q <= hit ? mem_q[slot] : {W{1'b0}};
      end
    end
  end

endmodule

/* File: rtl/ccc_i2c_rx.v */
module ccc_i2c_rx (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       ce,
  input  wire       enable,
  input  wire       busy,
  input  wire [6:0] dev_addr,
  input  wire       scl_s,
  input  wire       sda_s,
  output reg        sda_oe_q,
  output reg        byte_p_q,
  output reg        stop_p_q,
  output reg  [7:0] data_q
);

  localparam S_IDLE = 4'b0001;
  localparam S_RX   = 4'b0010;
  localparam S_ACK  = 4'b0100;
  localparam S_IGN  = 4'b1000;

  reg [3:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sr_q;
  reg       scl_q;
  reg       sda_q;
  reg       first_q;
  reg       sel_q;

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start    = scl_s & scl_q & sda_q & ~sda_s;
  wire stop     = scl_s & scl_q & ~sda_q & sda_s;
  // busy refuses the address, so the master sees no acknowledge
  wire adr_hit  = enable & ~busy & (sr_q[7:1] == dev_addr) & ~sr_q[0];

  always @(posedge clk_sys) begin
    if (rst) begin
      st_q     <= S_IDLE;
      bit_q    <= 4'h0;
      sr_q     <= 8'h00;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      first_q  <= 1'b0;
      sel_q    <= 1'b0;
      sda_oe_q <= 1'b0;
      byte_p_q <= 1'b0;
      stop_p_q <= 1'b0;
      data_q   <= 8'h00;
    end else if (ce) begin
      scl_q    <= scl_s;
      sda_q    <= sda_s;
      byte_p_q <= 1'b0;
      stop_p_q <= 1'b0;
      if (start) begin
        st_q     <= S_RX;
        bit_q    <= 4'h0;
        first_q  <= 1'b1;
        sda_oe_q <= 1'b0;
      end else if (stop) begin
        st_q     <= S_IDLE;
        sda_oe_q <= 1'b0;
        stop_p_q <= sel_q;
        sel_q    <= 1'b0;
      end else begin
        case (st_q)
          S_RX: begin
            if (scl_rise) begin
              sr_q  <= {sr_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q   <= 4'h0;
              first_q <= 1'b0;
              if (!first_q || adr_hit) begin
                sda_oe_q <= 1'b1;
                st_q     <= S_ACK;
                sel_q    <= 1'b1;
                byte_p_q <= ~first_q;
                data_q   <= sr_q;
              end else begin
                st_q <= S_IGN;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              st_q     <= S_RX;
            end
          end
          S_IDLE, S_IGN: begin
            st_q <= st_q;
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: rtl/ccc_config_control.v */
`include "ccc_defs.vh"

module ccc_config_control #(
  parameter [23:0]  POR_CYCLES    = `CCC_POR_TIME_US * `CCC_CLK_MHZ,
  parameter [23:0]  SETTLE_CYCLES = `CCC_SEL_SETTLE_US * `CCC_CLK_MHZ,
  parameter [7:0]   NVM_OP_CYCLES = `CCC_NVM_OP_CYCLES,
  parameter [199:0] NVM_INIT      = 200'h0
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       ce,
  input  wire       interface_select_strap,
  input  wire       config_select_low,
  input  wire       config_select_high,
  input  wire       shutdown_or_enable_pin,
  input  wire       scl,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  output reg        config_ready_q,
  output reg        i2c_access_en_q,
  output reg        nvm_busy_q,
  output reg  [2:0] active_config_q,
  output reg  [6:0] i2c_addr_q,
  output reg  [5:0] crystal_load_trim_q,
  output reg  [6:0] xtal_cap_half_pf_q,
  output reg        spread_en_q,
  output reg        spread_down_q,
  output reg  [3:0] spread_code_q,
  output reg        pll_shutdown_q,
  output reg  [3:0] out_drive_en_q,
  output reg  [3:0] out_hold_q,
  output reg        out_se_low_q
);

  localparam ST_POR  = 5'b00001;
  localparam ST_FLAG = 5'b00010;
  localparam ST_LOAD = 5'b00100;
  localparam ST_RUN  = 5'b01000;
  localparam ST_BUSY = 5'b10000;
  localparam W       = 8 * `CCC_NREG;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [2:0] reg_index;
    input [7:0] ptr;
    begin
      case (ptr)
        `CCC_REG_FLAGS:  reg_index = `CCC_IDX_FLAGS;
        `CCC_REG_PIN:    reg_index = `CCC_IDX_PIN;
        `CCC_REG_XTAL:   reg_index = `CCC_IDX_XTAL;
        `CCC_REG_OUT:    reg_index = `CCC_IDX_OUT;
        `CCC_REG_SPREAD: reg_index = `CCC_IDX_SPREAD;
        default:         reg_index = `CCC_IDX_NONE;
      endcase
    end
  endfunction

  function [3:0] ss_clamp;
    input [3:0] code;
    begin
      if (code < `CCC_SS_CODE_MIN) begin
        ss_clamp = `CCC_SS_CODE_MIN;
      end else if (code > `CCC_SS_CODE_MAX) begin
        ss_clamp = `CCC_SS_CODE_MAX;
      end else begin
        ss_clamp = code;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg  [5:0] sy1_q;
  reg  [5:0] sy2_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      sy1_q <= `CCC_SYNC_RST;
      sy2_q <= `CCC_SYNC_RST;
    end else if (ce) begin
      sy1_q <= {sda_in, scl, shutdown_or_enable_pin,
                config_select_high, config_select_low, interface_select_strap};
      sy2_q <= sy1_q;
    end
  end

  wire       strap_s = sy2_q[0];
  wire [1:0] sel_s   = sy2_q[2:1];
  wire       pin_s   = sy2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg  [4:0]   st_q;
  reg  [1:0]   wait_q;
  reg          strap_q;
  reg          flag_q;
  reg  [2:0]   slot_q;
  reg  [1:0]   sel_code_q;
  reg  [23:0]  por_cnt_q;
  reg  [23:0]  settle_cnt_q;
  reg  [7:0]   op_cnt_q;
  reg          op_rd_q;
  reg  [2:0]   nb_q;
  reg  [7:0]   ptr_q;
  reg  [7:0]   cmd_q;
  reg  [W-1:0] work_q;
  reg  [W-1:0] shadow_q;
  reg          nvm_rd;
  reg          nvm_wr;
  reg  [2:0]   nvm_slot;
  wire [W-1:0] nvm_rdata;
  wire         byte_p;
  wire         stop_p;
  wire [7:0]   rx_data;

  wire por_done    = (por_cnt_q == POR_CYCLES);
  wire settle_done = (settle_cnt_q == SETTLE_CYCLES);
  wire [2:0] ptr_idx = reg_index(ptr_q);

  // pin changes after a load are only followed when the strap chose them and the flag is clear
  wire sel_reload = (st_q == ST_RUN) & strap_q & ~flag_q & por_done & settle_done
                    & (sel_s != sel_code_q);
  wire cmd_save   = cmd_q[`CCC_SAVE_BIT];
  wire cmd_rest   = cmd_q[`CCC_RESTORE_BIT];
  wire cmd_go     = stop_p & (nb_q == 3'h1) & (cmd_save | cmd_rest);
  wire commit_go  = stop_p & (nb_q > 3'h1);

  wire flag_rd    = nvm_rdata[8 * `CCC_IDX_FLAGS + `CCC_FLAG_BIT];
  wire [2:0] boot_slot = strap_q ? {1'b0, sel_s} :
                         (flag_rd ? `CCC_SLOT_I2C : 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // storage port

  always @* begin
    nvm_rd   = 1'b0;
    nvm_wr   = 1'b0;
    nvm_slot = slot_q;
    case (st_q)
      ST_POR: begin
        nvm_rd   = (wait_q == 2'h3);
        nvm_slot = 3'h0;
      end
      ST_FLAG: begin
        nvm_rd   = 1'b1;
        nvm_slot = boot_slot;
      end
      ST_RUN: begin
        if (sel_reload) begin
          nvm_rd   = 1'b1;
          nvm_slot = {1'b0, sel_s};
        end else if (cmd_go) begin
          // save wins when both bits are set
          nvm_wr = cmd_save;
          nvm_rd = ~cmd_save;
        end
      end
      default: begin
        nvm_rd = 1'b0;
      end
    endcase
  end

  ccc_nvm_store #(
    .W    (W),
    .N    (`CCC_NSLOT),
    .INIT (NVM_INIT)
  ) u_nvm (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .rd_en   (nvm_rd),
    .wr_en   (nvm_wr),
    .slot    (nvm_slot),
    .wdata   (work_q),
    .rdata_q (nvm_rdata)
  );

  ccc_i2c_rx u_i2c (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .enable   (i2c_access_en_q),
    .busy     (nvm_busy_q),
    .dev_addr (i2c_addr_q),
    .scl_s    (sy2_q[4]),
    .sda_s    (sy2_q[5]),
    .sda_oe_q (sda_oe),
    .byte_p_q (byte_p),
    .stop_p_q (stop_p),
    .data_q   (rx_data)
  );

  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always @(posedge clk_sys) begin
    if (rst) begin
      st_q           <= ST_POR;
      wait_q         <= 2'h0;
      strap_q        <= 1'b0;
      flag_q         <= 1'b0;
      slot_q         <= 3'h0;
      sel_code_q     <= 2'h0;
      por_cnt_q      <= 24'h000000;
      settle_cnt_q   <= 24'h000000;
      op_cnt_q       <= 8'h00;
      op_rd_q        <= 1'b0;
      nb_q           <= 3'h0;
      ptr_q          <= 8'h00;
      cmd_q          <= 8'h00;
      work_q         <= {W{1'b0}};
      shadow_q       <= {W{1'b0}};
      config_ready_q <= 1'b0;
      nvm_busy_q     <= 1'b0;
    end else if (ce) begin
      if (!por_done) begin
        por_cnt_q <= por_cnt_q + 24'h000001;
      end
      if (!settle_done) begin
        settle_cnt_q <= settle_cnt_q + 24'h000001;
      end
      if (byte_p) begin
        nb_q <= (nb_q == 3'h7) ? nb_q : nb_q + 3'h1;
        if (nb_q == 3'h0) begin
          ptr_q <= rx_data;
          cmd_q <= rx_data;
        end else begin
          ptr_q <= ptr_q + 8'h01;
          if (ptr_idx != `CCC_IDX_NONE) begin
            shadow_q[ptr_idx*8 +: 8] <= rx_data;
          end
        end
      end
      if (stop_p) begin
        nb_q <= 3'h0;
      end
      case (st_q)
        ST_POR: begin
          // waits for the strap to clear both synchroniser stages
          if (wait_q == 2'h3) begin
            strap_q <= strap_s;
            st_q    <= ST_FLAG;
          end else begin
            wait_q <= wait_q + 2'h1;
          end
        end
        ST_FLAG: begin
          flag_q     <= flag_rd;
          slot_q     <= boot_slot;
          sel_code_q <= sel_s;
          st_q       <= ST_LOAD;
        end
        ST_LOAD: begin
          work_q         <= nvm_rdata;
          shadow_q       <= nvm_rdata;
          config_ready_q <= 1'b1;
          st_q           <= op_rd_q ? ST_BUSY : ST_RUN;
        end
        ST_RUN: begin
          if (sel_reload) begin
            slot_q       <= {1'b0, sel_s};
            sel_code_q   <= sel_s;
            settle_cnt_q <= 24'h000000;
            st_q         <= ST_LOAD;
          end else if (cmd_go) begin
            nvm_busy_q <= 1'b1;
            op_rd_q    <= ~cmd_save;
            op_cnt_q   <= 8'h00;
            st_q       <= cmd_save ? ST_BUSY : ST_LOAD;
          end else if (commit_go) begin
            work_q <= shadow_q;
          end
        end
        ST_BUSY: begin
          op_cnt_q <= op_cnt_q + 8'h01;
          if (op_cnt_q >= NVM_OP_CYCLES - 8'h01) begin
            nvm_busy_q <= 1'b0;
            op_rd_q    <= 1'b0;
            st_q       <= ST_RUN;
          end
        end
        default: begin
          st_q <= ST_POR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls

  wire [7:0] pin_reg = work_q[8 * `CCC_IDX_PIN +: 8];
  wire [7:0] out_reg = work_q[8 * `CCC_IDX_OUT +: 8];
  wire [7:0] ss_reg  = work_q[8 * `CCC_IDX_SPREAD +: 8];
  wire       pol     = pin_reg[`CCC_POL_BIT];
  wire       fnc     = pin_reg[`CCC_FN_BIT];
  wire       asserted = pol ? pin_s : ~pin_s;
  wire       shut     = fnc & asserted;
  wire       oe_off   = ~fnc & ~asserted;

  always @(posedge clk_sys) begin
    if (rst) begin
      i2c_access_en_q     <= 1'b0;
      active_config_q     <= 3'h0;
      i2c_addr_q          <= `CCC_ADDR_PRI;
      crystal_load_trim_q <= 6'h00;
      xtal_cap_half_pf_q  <= `CCC_XTAL_BASE;
      spread_en_q         <= 1'b0;
      spread_down_q       <= 1'b0;
      spread_code_q       <= `CCC_SS_CODE_MIN;
      pll_shutdown_q      <= 1'b0;
      out_drive_en_q      <= 4'h0;
      out_hold_q          <= 4'h0;
      out_se_low_q        <= 1'b0;
    end else if (ce) begin
      i2c_access_en_q     <= ~strap_q & config_ready_q;
      active_config_q     <= slot_q;
      i2c_addr_q          <= work_q[8 * `CCC_IDX_FLAGS + `CCC_ADDR_BIT] ?
                             `CCC_ADDR_SEC : `CCC_ADDR_PRI;
      crystal_load_trim_q <= work_q[8 * `CCC_IDX_XTAL +: 6];
      // units of half a picofarad above the fixed base
      xtal_cap_half_pf_q  <= `CCC_XTAL_BASE + {1'b0, work_q[8 * `CCC_IDX_XTAL +: 6]};
      spread_en_q         <= ss_reg[`CCC_SS_EN_BIT];
      spread_down_q       <= ss_reg[`CCC_SS_DOWN_BIT];
      spread_code_q       <= ss_clamp(ss_reg[3:0]);
      pll_shutdown_q      <= shut;
      out_se_low_q        <= shut;
      out_drive_en_q      <= out_reg[3:0];
      out_hold_q          <= out_reg[3:0] &
                             ({4{shut}} | ({4{oe_off}} & out_reg[7:4]));
    end
  end

endmodule

/* File: tb/ccc_config_monitor.sv */
module ccc_config_monitor #(
  parameter [7:0] NVM_OP_CYCLES = 8'h40
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       interface_select_strap,
  input wire logic       config_select_low,
  input wire logic       config_select_high,
  input wire logic       sda_oe,
  input wire logic       config_ready_q,
  input wire logic       i2c_access_en_q,
  input wire logic       nvm_busy_q,
  input wire logic [2:0] active_config_q,
  input wire logic [6:0] i2c_addr_q,
  input wire logic [5:0] crystal_load_trim_q,
  input wire logic [6:0] xtal_cap_half_pf_q,
  input wire logic       pll_shutdown_q,
  input wire logic [3:0] out_drive_en_q,
  input wire logic [3:0] out_hold_q,
  input wire logic       out_se_low_q
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUSY_MIN = NVM_OP_CYCLES;
  logic [8:0] busy_cnt_q;
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // counter instead of a long repetition, keeps the tools fast
  always_ff @(posedge clk_sys) busy_cnt_q <= (rst || !nvm_busy_q) ? 9'h000 : busy_cnt_q + 9'h001;
  ////////////////////////////////////////
  property p_addr; i2c_addr_q == 7'h6A || i2c_addr_q == 7'h68; endproperty
  a_addr: assert property (p_addr) else $error("bus address illegal");
  property p_xtal; $stable(crystal_load_trim_q) && $past(crystal_load_trim_q) == $past(crystal_load_trim_q, 2)
    |-> xtal_cap_half_pf_q == 7'h12 + {1'b0, crystal_load_trim_q}; endproperty
  a_xtal: assert property (p_xtal) else $error("capacitance code off");
  property p_bank; $rose(config_ready_q) && interface_select_strap
    |-> active_config_q == {1'b0, config_select_high, config_select_low} && !i2c_access_en_q; endproperty
  a_bank: assert property (p_bank) else $error("strap high load wrong");
  property p_flag; $rose(config_ready_q) && !interface_select_strap
    |=> i2c_access_en_q && (active_config_q == 3'h0 || active_config_q == 3'h4); endproperty
  a_flag: assert property (p_flag) else $error("strap low load wrong");
  property p_ack; sda_oe |-> i2c_access_en_q && !nvm_busy_q; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge while barred");
  property p_busy; busy_cnt_q <= BUSY_MIN + 1 && (!$fell(nvm_busy_q) || busy_cnt_q >= BUSY_MIN); endproperty
  a_busy: assert property (p_busy) else $error("command length wrong");
  property p_sd_pair; pll_shutdown_q == out_se_low_q; endproperty
  a_sd_pair: assert property (p_sd_pair) else $error("single ended not low");
  property p_sd_hold; pll_shutdown_q |-> out_hold_q == out_drive_en_q; endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("shutdown outputs not held");
endmodule

bind ccc_config_control ccc_config_monitor #(.NVM_OP_CYCLES(NVM_OP_CYCLES)) ccc_config_monitor_inst (.*);

/* File: tb/ccc_bus_master.sv */
module ccc_bus_master (
  output logic     scl,
  output logic     sda_pull,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime QTR = 31.25;
  // clock rests high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #QTR sda_pull = ~b;
    #QTR scl = 1'b1;
    #QTR r = sda_line;
    #QTR scl = 1'b0;
  endtask
  // address with write bit, n bytes, stop; ack msb is the address
  task automatic frame(input logic [6:0] adr, input logic [15:0] dat, input int n, output logic [2:0] ack);
    logic [7:0] byt;
    logic       r;
    ack = 3'b000;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    for (int k = 0; k <= n; k++) begin
      byt = (k == 0) ? {adr, 1'b0} : (k == 1) ? dat[15:8] : dat[7:0];
      for (int i = 7; i >= 0; i--) bit_io(byt[i], r);
      bit_io(1'b1, r);
      ack[2 - k] = ~r;
    end
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #QTR;
  endtask
  // bus counts as busy until the address is taken again
  task automatic wait_idle(input logic [6:0] adr, output logic ok);
    logic [2:0] a;
    ok = 1'b0;
    for (int t = 0; t < 40 && !ok; t++) begin
      frame(adr, 16'h0000, 0, a);
      ok = a[2];
    end
  endtask
endmodule

/* File: tb/clock_gen_config_control_tb.sv */
module clock_gen_config_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [3:0] sel; logic [7:0] val;} ccc_note_t;
  localparam logic [13:0] PIN_TAB [8] = '{14'h05F, 14'h060, 14'h0FF, 14'h0C0, 14'h023, 14'h000, 14'h083, 14'h0A0};
  ccc_note_t   note_q[$];
  ccc_note_t   cur;
  event        look;
  int          err_total;
  int          total_checks;
  integer      seed;
  logic        clk_sys, rst, ce, strap, sel_lo, sel_hi, pin, ok;
  logic [2:0]  ack;
  logic [5:0]  trim, saved;
  logic [6:0]  dev;
  logic [7:0]  obs;
  logic [13:0] row;
  wire         scl, sda_pull, sda_out, sda_oe, config_ready_q, i2c_access_en_q, nvm_busy_q;
  wire         spread_en_q, spread_down_q, pll_shutdown_q, out_se_low_q;
  wire [2:0]   active_config_q;
  wire [6:0]   i2c_addr_q, xtal_cap_half_pf_q;
  wire [5:0]   crystal_load_trim_q;
  wire [3:0]   spread_code_q, out_drive_en_q, out_hold_q;
  // pull-up: released line reads high
  wire         sda_line = !(sda_pull || (sda_oe && !sda_out));
  ccc_config_control #(.POR_CYCLES(24'h14), .SETTLE_CYCLES(24'h28), .NVM_OP_CYCLES(8'hC8),
    .NVM_INIT(200'h150000)) ccc_config_control_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .interface_select_strap(strap), .config_select_low(sel_lo), .config_select_high(sel_hi),
    .shutdown_or_enable_pin(pin), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .config_ready_q(config_ready_q), .i2c_access_en_q(i2c_access_en_q), .nvm_busy_q(nvm_busy_q),
    .active_config_q(active_config_q), .i2c_addr_q(i2c_addr_q), .crystal_load_trim_q(crystal_load_trim_q),
    .xtal_cap_half_pf_q(xtal_cap_half_pf_q), .spread_en_q(spread_en_q), .spread_down_q(spread_down_q),
    .spread_code_q(spread_code_q), .pll_shutdown_q(pll_shutdown_q), .out_drive_en_q(out_drive_en_q),
    .out_hold_q(out_hold_q), .out_se_low_q(out_se_low_q));
  ccc_bus_master ccc_bus_master_inst (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic note(input logic [3:0] s, input logic [7:0] v);
    note_q.push_back('{s, v});
    -> look;
  endtask
  task automatic frm(input logic [6:0] a, input logic [15:0] d, input int n);
    ccc_bus_master_inst.frame(a, d, n, ack);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    frm(dev, {r, v}, 2);
    cyc(10);
  endtask
  task automatic boot(input logic s, input logic h, input logic l);
    strap = s;
    sel_hi = h;
    sel_lo = l;
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    cyc(17);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  always @(look) begin
    while (note_q.size() > 0) begin
      cur = note_q.pop_front();
      case (cur.sel)
        4'h0: obs = {5'h00, active_config_q};
        4'h1: obs = {7'h00, i2c_access_en_q};
        4'h2: obs = {1'b0, i2c_addr_q};
        4'h3: obs = {2'h0, crystal_load_trim_q};
        4'h4: obs = {1'b0, xtal_cap_half_pf_q};
        4'h5: obs = {7'h00, pll_shutdown_q};
        4'h6: obs = {7'h00, out_se_low_q};
        4'h7: obs = {4'h0, out_hold_q};
        4'h8: obs = {4'h0, out_drive_en_q};
        4'h9: obs = {7'h00, nvm_busy_q};
        4'hA: obs = {5'h00, ack};
        4'hB: obs = {4'h0, spread_code_q};
        4'hD: obs = {7'h00, ok};
        default: obs = {6'h00, spread_en_q, spread_down_q};
      endcase
      chk(obs, cur.val);
    end
  end
  initial begin
    #400000;
    err_total++;
    close_out();
  end
  initial begin
    seed = 5;
    ce = 1'b1;
    pin = 1'b1;
    dev = 7'h6A;
    boot(1'b0, 1'b0, 1'b0);
    note(4'h1, 8'h01);
    note(4'h0, 8'h00);
    note(4'h2, 8'h6A);
    note(4'h3, 8'h15);
    for (int i = 0; i < 3; i++) begin
      trim = 6'($random(seed));
      wr(8'h12, {2'b00, trim});
      note(4'hA, 8'h07);
      note(4'h3, {2'b00, trim});
      note(4'h4, 8'h12 + trim);
    end
    wr(8'h22, 8'hCF);
    note(4'hB, 8'h0A);
    note(4'hC, 8'h03);
    wr(8'h22, 8'h80);
    note(4'hB, 8'h01);
    note(4'hC, 8'h02);
    wr(8'h20, 8'h3F);
    for (int i = 0; i < 8; i++) begin
      row = PIN_TAB[i];
      wr(8'h10, row[13:6]);
      pin = row[5];
      cyc(8);
      note(4'h5, {7'h00, row[4]});
      note(4'h6, {7'h00, row[4]});
      note(4'h7, {4'h0, row[3:0]});
    end
    wr(8'h20, 8'h3A);
    note(4'h8, 8'h0A);
    saved = trim;
    frm(dev, 16'h0800, 1);
    cyc(4);
    note(4'h9, 8'h01);
    frm(dev, 16'h0000, 0);
    note(4'hA, 8'h00);
    ccc_bus_master_inst.wait_idle(dev, ok);
    note(4'hD, 8'h01);
    note(4'h9, 8'h00);
    wr(8'h12, 8'h2A);
    note(4'h3, 8'h2A);
    frm(dev, 16'h0100, 1);
    ccc_bus_master_inst.wait_idle(dev, ok);
    note(4'hD, 8'h01);
    cyc(4);
    note(4'h3, {2'b00, saved});
    note(4'h4, 8'h12 + saved);
    wr(8'h00, 8'h01);
    note(4'h2, 8'h68);
    dev = 7'h68;
    wr(8'h12, 8'h01);
    note(4'hA, 8'h07);
    frm(7'h6A, 16'h0000, 0);
    note(4'hA, 8'h00);
    cyc(1);
    boot(1'b1, 1'b1, 1'b0);
    note(4'h0, 8'h02);
    note(4'h1, 8'h00);
    frm(7'h6A, 16'h0000, 0);
    note(4'hA, 8'h00);
    cyc(20);
    sel_lo = 1'b1;
    cyc(9);
    note(4'h0, 8'h03);
    // deliberately early: must wait out the settle window
    sel_hi = 1'b0;
    cyc(15);
    note(4'h0, 8'h03);
    cyc(30);
    note(4'h0, 8'h01);
    // settle window over, so only the frozen enable can hold the reload back
    cyc(45);
    ce = 1'b0;
    sel_lo = 1'b0;
    cyc(20);
    note(4'h0, 8'h01);
    ce = 1'b1;
    cyc(12);
    note(4'h0, 8'h00);
    cyc(1);
    close_out();
  end
endmodule
